/* File: hdl/boot_seq_defines.svh */
// Message codes, frame layout and timing counts of the boot sequencing link.
// Assumes a 100 MHz core clock on both ends.
`ifndef BOOT_SEQ_DEFINES_SVH
`define BOOT_SEQ_DEFINES_SVH
`define CMD_LOAD 32'h0800_0000
`define CMD_SOFT_RESET 32'h0400_0000
`define CMD_SYS_REQ 32'h8100_0009
`define SUB_SWAP 32'h0000_0001
`define SUB_SLEEP 32'h0000_0011
`define CMD_BEGIN 32'h8300_0000
`define CODE_BOOT_START 32'h0000_0001
`define CODE_IMAGE_OK 32'h0000_0002
`define CODE_APP_STARTED 32'h0000_0004
`define CODE_SWAP_ACK 32'h0000_0005
`define CODE_CHECKSUM_ERR 32'h0000_00FF
`define MASTER_IMAGE_ADDR 16'h0000
`define FRAME_DIR_BIT 6'h00
`define FRAME_LAST_BIT 6'h20
`define FRAME_TAIL_BIT 6'h21
`define GPIO_WIDTH 8
`define CLK_PERIOD_NS 10
`define LINK_HALF_CYCLES 8
`define LINK_HALF_LAST 4'(`LINK_HALF_CYCLES - 1)
`define PEND_SETTLE_CYCLES 4'hF
`define RESET_LOW_NS 1000
`define RESET_LOW_CYCLES 32'((`RESET_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PEND_TIMEOUT_US 10000
`define PEND_TIMEOUT_CYCLES ((`PEND_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`endif

/* File: hdl/boot_seq_pkg.sv */
// Types shared by both ends of the boot sequencing link.
// Assumes nothing beyond a SystemVerilog compiler.
package boot_seq_pkg;
  typedef enum logic [2:0] {
    dev_reset_hold, dev_master_fetch, dev_loader, dev_loading, dev_app, dev_sleep
  } dev_state_type;
  typedef enum logic [4:0] {
    h_idle, h_rst_low, h_rst_gap, h_load, h_send, h_await, h_read, h_image, h_soft,
    h_config, h_kick, h_swap, h_swap2, h_drain, h_drain_rd, h_sleep2, h_finish
  } host_state_type;
  typedef enum logic [1:0] {op_boot, op_swap, op_sleep} host_op_type;
  typedef enum logic [1:0] {st_ok, st_timeout, st_bad_code, st_restart} host_status_type;
endpackage : boot_seq_pkg

/* File: hdl/boot_link_if.sv */
// Pins between the host sequencer and the device loader.
// Assumes the bench joins both ends; open-drain lines resolve here with a pull-up.
`timescale 1ns/1ps
`default_nettype none
interface boot_link_if;
  logic link_clk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic dsp_reset_n;
  logic message_pending_n_o;
  logic message_pending_n_oe_n;
  logic message_pending_n;
  logic input_full_n_o;
  logic input_full_n_oe_n;
  logic input_full_n;
  // Released line floats high through the pull-up
  assign message_pending_n = message_pending_n_oe_n | message_pending_n_o;
  assign input_full_n = input_full_n_oe_n | input_full_n_o;
  modport dev (
    input link_clk, cs_n, mosi, dsp_reset_n,
    output miso, message_pending_n_o, message_pending_n_oe_n, input_full_n_o, input_full_n_oe_n
  );
  modport host (
    output link_clk, cs_n, mosi, dsp_reset_n,
    input miso, message_pending_n, input_full_n
  );
endinterface : boot_link_if
`default_nettype wire

/* File: hdl/overlay_dev_end.sv */
// Device end: loader, overlay swap, low power entry and message outbox.
// Assumes link pins come from another domain and the fetch port shares core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_defines.svh"
module overlay_dev_end (
  input wire logic core_clk,
  input wire logic rst,
  boot_link_if.dev link,
  input wire logic master_boot_strap,
  output logic fetch_req,
  output logic [15:0] fetch_addr,
  input wire logic [31:0] fetch_data,
  input wire logic fetch_valid,
  input wire logic [`GPIO_WIDTH-1:0] gpio_out_req,
  input wire logic [`GPIO_WIDTH-1:0] gpio_oe_n_req,
  output logic [`GPIO_WIDTH-1:0] gpio_out,
  output logic [`GPIO_WIDTH-1:0] gpio_oe_n,
  output logic gpio_pullup,
  output logic audio_running,
  output logic slave_port_on
);
  import boot_seq_pkg::*;
  logic [1:0] lclk_s, cs_s, mosi_s, rstn_s, strap_s;
  logic lclk_d, rstn_d;
  logic rise, frame_on, hard_reset, reset_release, last_rise, listening, rx_take, read_done;
  logic [31:0] rx_word, img_word;
  logic img_in, img_done, img_ok;
  logic [5:0] bit_r;
  logic dir_r, miso_r;
  logic [31:0] rx_sh_r, tx_sh_r, outbox_r, img_left_r, img_sum_r;
  logic outbox_valid_r, sys_pend_r, running_r, port_on_r, fetch_req_r, img_hdr_r;
  logic [15:0] fetch_addr_r;
  logic pend_oe_n_r, full_oe_n_r;
  dev_state_type state_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lclk_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      // Idle high, so leaving rst does not fake a reset release
      rstn_s <= 2'h3;
      strap_s <= 2'h0;
      lclk_d <= 1'b0;
      rstn_d <= 1'b1;
    end else begin
      lclk_s <= {lclk_s[0], link.link_clk};
      cs_s <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      rstn_s <= {rstn_s[0], link.dsp_reset_n};
      strap_s <= {strap_s[0], master_boot_strap};
      lclk_d <= lclk_s[1];
      rstn_d <= rstn_s[1];
    end
  end

  assign rise = lclk_s[1] & ~lclk_d;
  assign frame_on = ~cs_s[1];
  assign hard_reset = ~rstn_s[1];
  assign reset_release = rstn_s[1] & ~rstn_d;
  assign last_rise = frame_on & rise & (bit_r == `FRAME_LAST_BIT);
  assign rx_word = {rx_sh_r[30:0], mosi_s[1]};
  // Words are dropped in low power, so the device stays silent
  assign listening = port_on_r & (state_r inside {dev_loader, dev_loading, dev_app});
  assign rx_take = last_rise & ~dir_r & listening;
  assign read_done = last_rise & dir_r;

  // One frame: a direction bit then 32 data bits, sampled on link rising edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_r <= 6'h00;
      dir_r <= 1'b0;
      miso_r <= 1'b0;
      rx_sh_r <= 32'h0000_0000;
      tx_sh_r <= 32'h0000_0000;
    end else if (!frame_on) begin
      bit_r <= 6'h00;
    end else if (rise && bit_r != `FRAME_TAIL_BIT) begin
      bit_r <= bit_r + 6'h01;
      if (bit_r == `FRAME_DIR_BIT) begin
        dir_r <= mosi_s[1];
        miso_r <= outbox_r[31];
        tx_sh_r <= {outbox_r[30:0], 1'b0};
      end else begin
        rx_sh_r <= rx_word;
        miso_r <= tx_sh_r[31];
        tx_sh_r <= {tx_sh_r[30:0], 1'b0};
      end
    end
  end

  // Image layout: word count, that many words, then their 32-bit sum
  assign img_word = (state_r == dev_master_fetch) ? fetch_data : rx_word;
  assign img_in = (state_r == dev_master_fetch) ? (fetch_valid & fetch_req_r) : ((state_r == dev_loading) & rx_take);
  assign img_done = img_in & ~img_hdr_r & (img_left_r == 32'h0000_0000);
  assign img_ok = img_word == img_sum_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= dev_reset_hold;
      outbox_r <= 32'h0000_0000;
      outbox_valid_r <= 1'b0;
      sys_pend_r <= 1'b0;
      running_r <= 1'b0;
      port_on_r <= 1'b0;
      fetch_req_r <= 1'b0;
      fetch_addr_r <= `MASTER_IMAGE_ADDR;
      img_hdr_r <= 1'b1;
      img_left_r <= 32'h0000_0000;
      img_sum_r <= 32'h0000_0000;
    end else if (hard_reset) begin
      state_r <= dev_reset_hold;
      outbox_valid_r <= 1'b0;
      sys_pend_r <= 1'b0;
      running_r <= 1'b0;
      port_on_r <= 1'b0;
      fetch_req_r <= 1'b0;
    end else begin
      // A message posted below in the same cycle wins over this clear
      if (read_done) begin
        outbox_valid_r <= 1'b0;
        outbox_r <= 32'h0000_0000;
      end
      if (img_in && img_hdr_r) begin
        img_left_r <= img_word;
        img_sum_r <= 32'h0000_0000;
        img_hdr_r <= 1'b0;
      end else if (img_in && img_left_r != 32'h0000_0000) begin
        img_sum_r <= img_sum_r + img_word;
        img_left_r <= img_left_r - 32'h0000_0001;
      end
      if (img_in && state_r == dev_master_fetch) begin
        fetch_addr_r <= fetch_addr_r + 16'h0001;
      end
      case (state_r)
        dev_reset_hold: begin
          if (reset_release) begin
            img_hdr_r <= 1'b1;
            fetch_addr_r <= `MASTER_IMAGE_ADDR;
            if (strap_s[1]) begin
              state_r <= dev_master_fetch;
              fetch_req_r <= 1'b1;
            end else begin
              state_r <= dev_loader;
              port_on_r <= 1'b1;
            end
          end
        end
        dev_master_fetch: begin
          if (img_done) begin
            fetch_req_r <= 1'b0;
            port_on_r <= 1'b1;
            state_r <= img_ok ? dev_app : dev_loader;
          end
        end
        dev_loader: begin
          if (rx_take && rx_word == `CMD_LOAD) begin
            state_r <= dev_loading;
            img_hdr_r <= 1'b1;
            outbox_r <= `CODE_BOOT_START;
            outbox_valid_r <= 1'b1;
          end else if (rx_take && rx_word == `CMD_SOFT_RESET) begin
            state_r <= dev_app;
            outbox_r <= `CODE_APP_STARTED;
            outbox_valid_r <= 1'b1;
          end
        end
        dev_loading: begin
          if (img_done) begin
            state_r <= dev_loader;
            outbox_r <= img_ok ? `CODE_IMAGE_OK : `CODE_CHECKSUM_ERR;
            outbox_valid_r <= 1'b1;
          end
        end
        dev_app: begin
          if (rx_take) begin
            sys_pend_r <= rx_word == `CMD_SYS_REQ;
            if (sys_pend_r && rx_word == `SUB_SWAP) begin
              state_r <= dev_loader;
              running_r <= 1'b0;
              outbox_r <= `CODE_SWAP_ACK;
              outbox_valid_r <= 1'b1;
            end else if (sys_pend_r && rx_word == `SUB_SLEEP) begin
              state_r <= dev_sleep;
              running_r <= 1'b0;
            end else if (rx_word == `CMD_BEGIN) begin
              running_r <= 1'b1;
            end
          end
        end
        dev_sleep: begin
          state_r <= dev_sleep;
        end
        default: begin
          state_r <= dev_reset_hold;
        end
      endcase
    end
  end

  // Busy while the port is not yet a slave; pending while the outbox holds a word
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_oe_n_r <= 1'b1;
      full_oe_n_r <= 1'b1;
    end else begin
      pend_oe_n_r <= ~outbox_valid_r;
      full_oe_n_r <= port_on_r;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gpio_out <= {`GPIO_WIDTH{1'b0}};
      gpio_oe_n <= {`GPIO_WIDTH{1'b1}};
      gpio_pullup <= 1'b0;
    end else if (state_r == dev_sleep) begin
      gpio_out <= {`GPIO_WIDTH{1'b0}};
      gpio_oe_n <= {`GPIO_WIDTH{1'b1}};
      gpio_pullup <= 1'b1;
    end else begin
      gpio_out <= gpio_out_req;
      gpio_oe_n <= gpio_oe_n_req;
      gpio_pullup <= 1'b0;
    end
  end

  assign link.miso = miso_r;
  assign link.message_pending_n_o = 1'b0;
  assign link.message_pending_n_oe_n = pend_oe_n_r;
  assign link.input_full_n_o = 1'b0;
  assign link.input_full_n_oe_n = full_oe_n_r;
  assign fetch_req = fetch_req_r;
  assign fetch_addr = fetch_addr_r;
  assign audio_running = running_r;
  assign slave_port_on = port_on_r;
endmodule : overlay_dev_end
`default_nettype wire

/* File: hdl/overlay_host_end.sv */
// Host end: drives the link clock, reset pin and word frames, and walks
// the boot, swap, sleep and wake sequences. Assumes the caller streams
// image and configuration words on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_defines.svh"
module overlay_host_end #(
  parameter int PEND_TIMEOUT_CYCLES = `PEND_TIMEOUT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  boot_link_if.host link,
  input wire logic op_valid,
  input wire boot_seq_pkg::host_op_type op,
  output logic op_ready,
  input wire logic word_valid,
  input wire logic [31:0] word_data,
  input wire logic word_end,
  input wire logic word_final,
  output logic word_ready,
  output logic done,
  output logic fail,
  output var boot_seq_pkg::host_status_type status,
  output logic [31:0] last_read
);
  import boot_seq_pkg::*;
  logic [1:0] miso_s, pend_s, full_s;
  logic streaming, x_read, x_req, x_start, pend_low, timed_out;
  logic [31:0] x_word;
  logic eng_on_r, eng_done_r, read_r, lclk_r, cs_n_r, mosi_r;
  logic [3:0] half_r, settle_r;
  logic [5:0] bit_r;
  logic [31:0] tx_sh_r, rx_sh_r;
  host_state_type state_r, ret_r, after_r;
  logic [31:0] cur_word_r, expect_r, timer_r;
  logic end_r, final_r, rst_n_r, op_ready_r, word_ready_r, done_r, fail_r;
  host_status_type status_r;
  logic [31:0] last_read_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      miso_s <= 2'h0;
      pend_s <= 2'h3;
      full_s <= 2'h3;
    end else begin
      miso_s <= {miso_s[0], link.miso};
      pend_s <= {pend_s[0], link.message_pending_n};
      full_s <= {full_s[0], link.input_full_n};
    end
  end

  assign streaming = (state_r == h_image) | (state_r == h_config);
  assign x_read = (state_r == h_read) | (state_r == h_drain_rd);
  assign x_req = (state_r == h_send) | x_read | (streaming & word_valid);
  assign x_start = x_req & ~eng_on_r & ~eng_done_r & (x_read | full_s[1]);
  assign x_word = streaming ? word_data : cur_word_r;
  // A just-read line takes a few cycles to rise, so it is ignored while settling
  assign pend_low = ~pend_s[1] & (settle_r == 4'h0);
  assign timed_out = timer_r == 32'(PEND_TIMEOUT_CYCLES - 1);

  // Frame engine; the link clock is divided from core_clk, data changes on its falls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eng_on_r <= 1'b0;
      eng_done_r <= 1'b0;
      read_r <= 1'b0;
      lclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      mosi_r <= 1'b0;
      half_r <= 4'h0;
      bit_r <= 6'h00;
      tx_sh_r <= 32'h0000_0000;
      rx_sh_r <= 32'h0000_0000;
    end else begin
      eng_done_r <= 1'b0;
      if (x_start) begin
        eng_on_r <= 1'b1;
        read_r <= x_read;
        cs_n_r <= 1'b0;
        mosi_r <= x_read;
        tx_sh_r <= x_word;
        half_r <= 4'h0;
        bit_r <= `FRAME_DIR_BIT;
        lclk_r <= 1'b0;
      end else if (eng_on_r) begin
        if (half_r != `LINK_HALF_LAST) begin
          half_r <= half_r + 4'h1;
        end else begin
          half_r <= 4'h0;
          if (bit_r == `FRAME_TAIL_BIT) begin
            eng_on_r <= 1'b0;
            eng_done_r <= 1'b1;
          end else if (!lclk_r) begin
            lclk_r <= 1'b1;
            rx_sh_r <= {rx_sh_r[30:0], miso_s[1]};
          end else begin
            lclk_r <= 1'b0;
            bit_r <= bit_r + 6'h01;
            mosi_r <= tx_sh_r[31];
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            if (bit_r == `FRAME_LAST_BIT) begin
              cs_n_r <= 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_ready_r <= 1'b0;
      settle_r <= 4'h0;
    end else begin
      word_ready_r <= x_start & streaming;
      if (eng_done_r && read_r) begin
        settle_r <= `PEND_SETTLE_CYCLES;
      end else if (settle_r != 4'h0) begin
        settle_r <= settle_r - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= h_idle;
      ret_r <= h_idle;
      after_r <= h_idle;
      cur_word_r <= 32'h0000_0000;
      expect_r <= 32'h0000_0000;
      timer_r <= 32'h0000_0000;
      end_r <= 1'b0;
      final_r <= 1'b0;
      rst_n_r <= 1'b1;
      op_ready_r <= 1'b0;
      done_r <= 1'b0;
      fail_r <= 1'b0;
      status_r <= st_ok;
      last_read_r <= 32'h0000_0000;
    end else begin
      done_r <= 1'b0;
      fail_r <= 1'b0;
      op_ready_r <= 1'b0;
      if (x_start) begin
        end_r <= word_end;
        final_r <= word_final;
      end
      case (state_r)
        h_idle: begin
          op_ready_r <= ~(op_valid & op_ready_r);
          timer_r <= 32'h0000_0000;
          if (op_valid && op_ready_r) begin
            case (op)
              op_boot: begin
                // Also the wake path; the caller streams the matching wake image
                state_r <= h_rst_low;
                rst_n_r <= 1'b0;
              end
              op_swap: state_r <= h_swap;
              op_sleep: state_r <= h_drain;
              default: state_r <= h_idle;
            endcase
          end
        end
        h_rst_low: begin
          timer_r <= timer_r + 32'h0000_0001;
          if (timer_r == `RESET_LOW_CYCLES - 32'h0000_0001) begin
            rst_n_r <= 1'b1;
            timer_r <= 32'h0000_0000;
            state_r <= h_rst_gap;
          end
        end
        h_rst_gap: begin
          timer_r <= timer_r + 32'h0000_0001;
          if (timer_r == `RESET_LOW_CYCLES - 32'h0000_0001) begin
            state_r <= h_load;
          end
        end
        h_load: begin
          cur_word_r <= `CMD_LOAD;
          expect_r <= `CODE_BOOT_START;
          after_r <= h_image;
          ret_r <= h_await;
          state_r <= h_send;
        end
        h_send: begin
          timer_r <= 32'h0000_0000;
          if (eng_done_r) begin
            state_r <= ret_r;
          end
        end
        h_await: begin
          timer_r <= timer_r + 32'h0000_0001;
          if (pend_low) begin
            state_r <= h_read;
          end else if (timed_out) begin
            fail_r <= 1'b1;
            status_r <= (expect_r == `CODE_APP_STARTED) ? st_restart : st_timeout;
            state_r <= h_idle;
          end
        end
        h_read: begin
          timer_r <= 32'h0000_0000;
          if (eng_done_r) begin
            last_read_r <= rx_sh_r;
            if (rx_sh_r == expect_r) begin
              state_r <= after_r;
            end else if (expect_r == `CODE_SWAP_ACK) begin
              state_r <= h_await;
            end else begin
              fail_r <= 1'b1;
              status_r <= st_bad_code;
              state_r <= h_idle;
            end
          end
        end
        h_image: begin
          timer_r <= 32'h0000_0000;
          if (eng_done_r && end_r) begin
            expect_r <= `CODE_IMAGE_OK;
            after_r <= final_r ? h_soft : h_load;
            state_r <= h_await;
          end
        end
        h_soft: begin
          cur_word_r <= `CMD_SOFT_RESET;
          expect_r <= `CODE_APP_STARTED;
          after_r <= h_config;
          ret_r <= h_await;
          state_r <= h_send;
        end
        h_config: begin
          if (eng_done_r && end_r) begin
            state_r <= h_kick;
          end
        end
        h_kick: begin
          cur_word_r <= `CMD_BEGIN;
          ret_r <= h_finish;
          state_r <= h_send;
        end
        h_swap: begin
          cur_word_r <= `CMD_SYS_REQ;
          ret_r <= h_swap2;
          state_r <= h_send;
        end
        h_swap2: begin
          cur_word_r <= `SUB_SWAP;
          expect_r <= `CODE_SWAP_ACK;
          after_r <= h_load;
          ret_r <= h_await;
          state_r <= h_send;
        end
        h_drain: begin
          if (pend_low) begin
            state_r <= h_drain_rd;
          end else if (settle_r == 4'h0) begin
            cur_word_r <= `CMD_SYS_REQ;
            ret_r <= h_sleep2;
            state_r <= h_send;
          end
        end
        h_drain_rd: begin
          if (eng_done_r) begin
            last_read_r <= rx_sh_r;
            state_r <= h_drain;
          end
        end
        h_sleep2: begin
          cur_word_r <= `SUB_SLEEP;
          ret_r <= h_finish;
          state_r <= h_send;
        end
        h_finish: begin
          done_r <= 1'b1;
          status_r <= st_ok;
          state_r <= h_idle;
        end
        default: begin
          state_r <= h_idle;
        end
      endcase
    end
  end

  assign link.link_clk = lclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = mosi_r;
  assign link.dsp_reset_n = rst_n_r;
  assign op_ready = op_ready_r;
  assign word_ready = word_ready_r;
  assign done = done_r;
  assign fail = fail_r;
  assign status = status_r;
  assign last_read = last_read_r;
endmodule : overlay_host_end
`default_nettype wire

/* File: verif/overlay_boot_assertions.sv */
// Checker on the boot link pins between host and device ends.
// Assumes the link signals are sampled on core_clk with rst asynchronous high.
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_defines.svh"
module overlay_boot_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic dsp_reset_n,
  input wire logic message_pending_n
);
  logic [9:0] low_r;
  logic [9:0] frame_r;
  logic [5:0] rises_r;
  logic clk_d_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) low_r <= 10'h000;
    else low_r <= dsp_reset_n ? 10'h000 : low_r + 10'h001;
  end
  // Frame length and clock rise count, both cleared while deselected
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_r <= 10'h000;
      rises_r <= 6'h00;
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= link_clk;
      frame_r <= cs_n ? 10'h000 : frame_r + 10'h001;
      rises_r <= cs_n ? 6'h00 : rises_r + 6'(link_clk & ~clk_d_r);
    end
  end
  property p_clk_idle; cs_n |-> !link_clk; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("link clock high outside a frame");
  property p_half; $rose(link_clk) |=> link_clk [*7] ##1 !link_clk; endproperty
  a_half: assert property (p_half) else $error("link clock high phase not 8 cycles");
  property p_mosi; link_clk && $past(link_clk) |-> $stable(mosi); endproperty
  a_mosi: assert property (p_mosi) else $error("data moved while link clock high");
  property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("frames closer than 8 cycles");
  property p_frame; $rose(cs_n) |-> frame_r == 10'h210 && rises_r == 6'h21; endproperty
  a_frame: assert property (p_frame) else $error("frame length or clock count wrong");
  property p_rst_pulse; $rose(dsp_reset_n) |-> low_r == 10'(`RESET_LOW_CYCLES); endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("hard reset pulse length wrong");
  property p_rst_gap; $rose(dsp_reset_n) |-> cs_n [*8]; endproperty
  a_rst_gap: assert property (p_rst_gap) else $error("frame too soon after hard reset");
  property p_pend_reset; $fell(dsp_reset_n) |-> ##8 message_pending_n; endproperty
  a_pend_reset: assert property (p_pend_reset) else $error("pending line held through reset");
endmodule : overlay_boot_assertions
`default_nettype wire

/* File: verif/overlay_boot_swap_sleep_sequencer_bench.sv */
// Bench joining host and device ends: boot, swap, bad image, sleep, wake.
// Assumes both ends share core_clk; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %h seen %h", nm, e, g); end end
module overlay_boot_swap_sleep_sequencer_bench;
  import boot_seq_pkg::*;
  typedef struct packed {host_op_type o; logic bad; host_status_type st;} row_type;
  logic core_clk = 0, rst = 1, op_valid = 0, word_valid = 0, word_end = 0, word_final = 0;
  host_op_type op = op_boot;
  logic [31:0] word_data = 32'h0, last_read;
  logic strap = 0, fetch_valid = 0;
  logic [31:0] fetch_data = 32'h0;
  logic [31:0] fetch_mem [4] = '{32'h0000_0002, 32'h1111_0000, 32'h2222_0000, 32'h3333_0000};
  logic [7:0] gpio_out_req = 8'hA5, gpio_oe_n_req = 8'h0F, gpio_out, gpio_oe_n;
  logic op_ready, word_ready, done, fail, fetch_req, gpio_pullup, audio_running, slave_port_on;
  logic [15:0] fetch_addr;
  host_status_type status;
  int mismatches = 0, compares = 0;
  row_type rows [5] = '{'{op_boot, 1'b0, st_ok}, '{op_swap, 1'b0, st_ok},
    '{op_boot, 1'b1, st_bad_code}, '{op_boot, 1'b0, st_ok}, '{op_sleep, 1'b0, st_ok}};
  boot_link_if link();
  overlay_host_end #(.PEND_TIMEOUT_CYCLES(2000)) u_overlay_host_end (.core_clk, .rst, .link(link.host),
    .op_valid, .op, .op_ready, .word_valid, .word_data, .word_end, .word_final, .word_ready,
    .done, .fail, .status, .last_read);
  overlay_dev_end u_overlay_dev_end (.core_clk, .rst, .link(link.dev), .master_boot_strap(strap),
    .fetch_req, .fetch_addr, .fetch_data, .fetch_valid, .gpio_out_req, .gpio_oe_n_req,
    .gpio_out, .gpio_oe_n, .gpio_pullup, .audio_running, .slave_port_on);
  overlay_boot_assertions u_overlay_boot_assertions (.core_clk, .rst, .link_clk(link.link_clk),
    .cs_n(link.cs_n), .mosi(link.mosi), .dsp_reset_n(link.dsp_reset_n),
    .message_pending_n(link.message_pending_n));
  always #5 core_clk = ~core_clk;
  // Boot memory answers in every cycle that the fetch is raised
  always @(negedge core_clk) begin
    fetch_valid <= fetch_req;
    fetch_data <= fetch_mem[fetch_addr[1:0]];
  end
  task automatic send_word(input logic [31:0] w, input logic e, input logic f);
    int n;
    @(negedge core_clk);
    word_valid = 1;
    word_data = w;
    word_end = e;
    word_final = f;
    for (n = 0; n < 20000 && word_ready !== 1'b1; n++) @(negedge core_clk);
    `CHK("word_ready", 1'b1, word_ready)
    word_valid = 0;
  endtask : send_word
  // Image is count, two words, checksum; a bad checksum must be refused
  task automatic run_op(input row_type r);
    int n;
    @(negedge core_clk);
    op_valid = 1;
    op = r.o;
    @(negedge core_clk);
    op_valid = 0;
    if (r.o != op_sleep && !strap) begin
      send_word(32'h0000_0002, 0, 0);
      send_word(32'h1111_0000, 0, 0);
      send_word(32'h2222_0000, 0, 0);
      send_word(r.bad ? 32'h0000_0BAD : 32'h3333_0000, 1, 1);
      if (!r.bad) send_word(32'h5555_AAAA, 1, 0);
    end
    for (n = 0; n < 20000 && done !== 1'b1 && fail !== 1'b1; n++) @(negedge core_clk);
    `CHK("done", r.st == st_ok, done)
    `CHK("fail", r.st != st_ok, fail)
    `CHK("status", r.st, status)
    if (r.o != op_sleep) `CHK("last_read", r.bad ? `CODE_CHECKSUM_ERR : `CODE_APP_STARTED, last_read)
    repeat (40) @(negedge core_clk);
    `CHK("audio_running", r.o != op_sleep && r.st == st_ok, audio_running)
  endtask : run_op
  task end_sim;
    $display("COUNTS compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Seven sequences of at most eight thousand cycles each fit well inside this span
  initial begin
    #950us;
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 0;
    for (int i = 0; i < 5; i++) begin
      run_op(rows[i]);
      $display("TEST row %0d finished", i);
    end
    `CHK("gpio_pullup", 1'b1, gpio_pullup)
    `CHK("gpio_oe_n", 8'hFF, gpio_oe_n)
    `CHK("gpio_out", 8'h00, gpio_out)
    run_op(rows[0]);
    `CHK("gpio_oe_n", 8'h0F, gpio_oe_n)
    `CHK("gpio_out", 8'hA5, gpio_out)
    $display("TEST wake finished");
    // Master boot lands in the application, so the host's load word goes unanswered
    strap = 1;
    run_op(row_type'{op_boot, 1'b0, st_timeout});
    `CHK("slave_port_on", 1'b1, slave_port_on)
    `CHK("fetch_addr", 16'h0004, fetch_addr)
    `CHK("fetch_req", 1'b0, fetch_req)
    strap = 0;
    $display("TEST master boot finished");
    rst = 1;
    @(negedge core_clk);
    `CHK("op_ready", 1'b0, op_ready)
    `CHK("audio_running", 1'b0, audio_running)
    `CHK("fetch_req", 1'b0, fetch_req)
    rst = 0;
    repeat (4) @(negedge core_clk);
    `CHK("op_ready", 1'b1, op_ready)
    `CHK("slave_port_on", 1'b0, slave_port_on)
    $display("TEST reset finished");
    end_sim();
  end
endmodule : overlay_boot_swap_sleep_sequencer_bench
`default_nettype wire
